// file: logic/irq_agg_pkg.sv
// constants, register map and state types shared by the interrupt aggregator
package irq_agg_pkg;

    // register byte offsets on the apb bus, one aligned word each
    localparam logic [7:0]  OFS_CORE_CTRL  = 8'h00;  // core_irq_control
    localparam logic [7:0]  OFS_REQ_ONE    = 8'h04;  // periph_request_one
    localparam logic [7:0]  OFS_REQ_TWO    = 8'h08;  // periph_request_two
    localparam logic [7:0]  OFS_EN_ONE     = 8'h0c;  // periph_enable_one
    localparam logic [7:0]  OFS_EN_TWO     = 8'h10;  // periph_enable_two
    localparam logic [7:0]  OFS_OPTION     = 8'h14;  // edge polarity select
    localparam logic [7:0]  OFS_PIN_CHANGE = 8'h18;  // per_pin_change_enable
    localparam logic [7:0]  OFS_CPU_STATE  = 8'h1c;  // read-only core state

    // field positions inside core_irq_control
    localparam int          BIT_GIE        = 7;      // global_irq_enable
    localparam int          BIT_PERIPHERAL_GROUP_ENABLE       = 6;      // peripheral_group_enable
    localparam int          BIT_TICK_EN    = 5;      // tick_overflow_enable
    localparam int          BIT_PIN_EN     = 4;      // ext_pin_enable
    localparam int          BIT_PORT_EN    = 3;      // port_change_enable
    localparam int          BIT_TICK_FLAG  = 2;      // tick_overflow_flag
    localparam int          BIT_PIN_FLAG   = 1;      // ext_pin_flag
    localparam int          BIT_PORT_FLAG  = 0;      // port_change_flag

    // field positions in the option and state registers
    localparam int          BIT_EDGE_POL   = 0;      // edge_polarity_select
    localparam int          BIT_SLEEPING   = 0;      // core is asleep
    localparam int          BIT_SVC_BUSY   = 1;      // vector jump under way

    // reset values and implemented bits
    localparam logic [7:0]  RST_REG        = 8'h00;  // registers clear, except edge polarity
    localparam logic [7:0]  REQ_TWO_MASK   = 8'hf5;  // implemented bits of pair two
    localparam logic        RST_EDGE_POL   = 1'b1;   // rising edge after reset

    // fixed vector the program counter is loaded with
    localparam logic [12:0] VECTOR_ADDR    = 13'h0004;

    // instruction-cycle phases, one ref_clk each
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} q_phase_e;

    // vector request sequencer states
    typedef enum logic [1:0] {SVC_IDLE, SVC_SYNC, SVC_DUMMY} svc_state_e;

endpackage : irq_agg_pkg

// file: logic/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync_out
);

    logic [W-1:0] meta_stage;   // first stage, read only by the second

    // both stages clear under reset, then follow the pins
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_stage   <= '0;
            pin_sync_out <= '0;
        end
        else
        begin
            meta_stage   <= pin_in;
            pin_sync_out <= meta_stage;
        end
    end

endmodule : pin_sync

// file: logic/q_phase_gen.sv
// quarter-cycle phase divider giving the q1..q4 phase and a q1 enable of the instruction cycle
`timescale 1ns/1ps
module q_phase_gen
    import irq_agg_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output q_phase_e  phase,
    output logic      q1_en
);

    // phase advances every clock, four clocks make one instruction cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            phase <= Q4;
        end
        else
        begin
            case (phase)
                Q1:      phase <= Q2;
                Q2:      phase <= Q3;
                Q3:      phase <= Q4;
                Q4:      phase <= Q1;
                default: phase <= Q1;
            endcase
        end
    end

    // one-cycle pulse marking the q1 phase
    assign q1_en = (phase == Q1);

endmodule : q_phase_gen

// file: logic/mcu_interrupt_aggregator.sv
// interrupt flag collection, gating, vector request and sleep wake-up
//
// Function
// - global enable gates all enabled sources
// - reset clears the global enable
// - return instruction sets global enable again
// - taking clears enable, pushes, loads vector
// - latency three to four instruction cycles
// - flags set regardless of any enable
// - clearing global enable defers pending interrupt
// - pin edge polarity selectable, edge sets flag
// - enabled pin wakes; vector only with enable
// - tick rollover sets flag, enable gates it
// - enabled port pin change sets change flag
// - change during port read may be lost
// - core control register bit layout fixed
// - two request/enable pairs, unused bits zero
// - pin flag set only in q4-q1
// - segment output function disables pin interrupt
// - after wake run next instruction, then vector
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module mcu_interrupt_aggregator
    import irq_agg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_irq_pin,
    input  wire logic        seg_output_active,
    input  wire logic [7:0]  change_port,
    input  wire logic        port_read,
    input  wire logic        tick_rollover,
    input  wire logic [7:0]  periph_event_one,
    input  wire logic [7:0]  periph_event_two,
    input  wire logic        sleep_entry,
    input  wire logic        return_from_irq,
    input  wire logic        gie_clear_exec,
    output logic             irq_take,
    output logic             push_return,
    output logic             vector_load,
    output logic      [12:0] vector_addr,
    output logic             irq_pending,
    output logic             wake_up,
    output logic             sleeping
);

    // register state
    logic       global_irq_enable;        // gie
    logic       peripheral_group_enable;  // peripheral_group_enable
    logic       tick_overflow_enable;     // timer source enable
    logic       ext_pin_enable;           // pin source enable
    logic       port_change_enable;       // port change source enable
    logic       tick_overflow_flag;       // timer rollover seen
    logic       ext_pin_flag;             // valid pin edge seen
    logic       port_change_flag;         // port mismatch seen
    logic [7:0] periph_request_one;       // peripheral flags, pair one
    logic [7:0] periph_request_two;       // peripheral flags, pair two
    logic [7:0] periph_enable_one;        // peripheral enables, pair one
    logic [7:0] periph_enable_two;        // peripheral enables, pair two
    logic       edge_polarity_select;     // 1 = rising, 0 = falling
    logic [7:0] per_pin_change_enable;    // pins taking part in change detect

    // synchronised pins and edge state
    logic       pin_synced;               // ext pin after two flops
    logic [7:0] port_synced;              // change port after two flops
    logic       pin_prev;                 // pin one clock earlier
    logic       edge_held;                // edge waiting for the q4-q1 window
    logic [7:0] port_latch;               // value seen by the last port read
    logic [2:0] sync_fill;                // no pin edges until the pipe has filled

    // phase, sequencer and bus helpers
    q_phase_e   phase;                    // current quarter of the cycle
    logic       q1_en;                    // q1 pulse
    svc_state_e svc_state;                // vector request sequencer
    logic [7:0] core_ctrl_value;          // assembled core control byte
    logic       wr_en;                    // write takes effect this edge
    logic       valid_edge;               // pin edge of the chosen polarity
    logic       edge_window;              // flag may be set in this phase
    logic       pin_event;                // pin edge accepted into the flag
    logic [7:0] port_mismatch;            // enabled pins differing from latch
    logic       port_event;               // change detected this cycle
    logic       core_request;             // a core source is flagged and enabled
    logic       periph_flagged;           // a peripheral source is flagged and enabled
    logic       any_request;              // gated request towards the cpu
    logic       take_now;                 // vector jump happens this edge

    // decode of an address to a mapped register
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            OFS_CORE_CTRL, OFS_REQ_ONE, OFS_REQ_TWO, OFS_EN_ONE,
            OFS_EN_TWO, OFS_OPTION, OFS_PIN_CHANGE, OFS_CPU_STATE:
                addr_mapped = 1'b1;
            default:
                addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // write strobe for one register offset
    function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                    input logic [7:0] ofs);
        wr_hit = en && (a == ofs);
    endfunction : wr_hit

    // pin synchronisers
    pin_sync #(.W(1)) u_pin_sync (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .pin_in       (ext_irq_pin),
        .pin_sync_out (pin_synced)
    );

    pin_sync #(.W(8)) u_port_sync (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .pin_in       (change_port),
        .pin_sync_out (port_synced)
    );

    // instruction-cycle phases
    q_phase_gen u_phase (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .phase   (phase),
        .q1_en   (q1_en)
    );

    // assembled core control byte, gie at the top down to the change flag
    assign core_ctrl_value = {global_irq_enable, peripheral_group_enable,
                              tick_overflow_enable, ext_pin_enable, port_change_enable,
                              tick_overflow_flag, ext_pin_flag, port_change_flag};

    // write takes effect only at the completing access edge
    assign wr_en = psel && penable && pready && pwrite;

    // edge of the selected polarity, blocked while the segment output owns the pin
    assign valid_edge  = sync_fill[2] && !seg_output_active &&
                         (edge_polarity_select ? (pin_synced && !pin_prev)
                                               : (!pin_synced && pin_prev));
    assign edge_window = (phase == Q4) || (phase == Q1);
    assign pin_event   = edge_window && (valid_edge || edge_held);

    // change against the last read value; a read this cycle hides it
    assign port_mismatch = (port_synced ^ port_latch) & per_pin_change_enable;
    assign port_event    = (|port_mismatch) && !port_read;

    // source gating towards the cpu and the wake-up logic
    assign core_request   = (tick_overflow_flag && tick_overflow_enable) ||
                            (ext_pin_flag && ext_pin_enable) ||
                            (port_change_flag && port_change_enable);
    assign periph_flagged = peripheral_group_enable &&
                            (|((periph_request_one & periph_enable_one) |
                               (periph_request_two & periph_enable_two)));
    assign any_request    = global_irq_enable && (core_request || periph_flagged);

    // jump on the third q1 unless gie was cleared meanwhile or right now
    assign take_now = q1_en && (svc_state == SVC_DUMMY) && any_request &&
                      !gie_clear_exec && !sleeping;

    // previous pin level and edge holding until the q4-q1 window
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pin_prev  <= 1'b0;
            sync_fill <= 3'h0;
            edge_held <= 1'b0;
        end
        else
        begin
            pin_prev <= pin_synced;
            sync_fill <= {sync_fill[1:0], 1'b1};
            // an edge outside the window waits for it
            if (edge_window)
            begin
                edge_held <= 1'b0;
            end
            else if (valid_edge)
            begin
                edge_held <= 1'b1;
            end
        end
    end

    // port latch follows the pins at each port read
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            port_latch <= RST_REG;
        end
        else if (port_read)
        begin
            port_latch <= port_synced;
        end
    end

    // global enable: cleared by reset, by the jump and by an instruction
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            global_irq_enable <= 1'b0;
        end
        else if (take_now)
        begin
            global_irq_enable <= 1'b0;
        end
        else if (return_from_irq)
        begin
            global_irq_enable <= 1'b1;
        end
        else if (gie_clear_exec)
        begin
            global_irq_enable <= 1'b0;
        end
        else if (wr_hit(wr_en, paddr, OFS_CORE_CTRL))
        begin
            global_irq_enable <= pwdata[BIT_GIE];
        end
    end

    // source enables in core_irq_control
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            peripheral_group_enable <= 1'b0;
            tick_overflow_enable    <= 1'b0;
            ext_pin_enable          <= 1'b0;
            port_change_enable      <= 1'b0;
        end
        else if (wr_hit(wr_en, paddr, OFS_CORE_CTRL))
        begin
            peripheral_group_enable <= pwdata[BIT_PERIPHERAL_GROUP_ENABLE];
            tick_overflow_enable    <= pwdata[BIT_TICK_EN];
            ext_pin_enable          <= pwdata[BIT_PIN_EN];
            port_change_enable      <= pwdata[BIT_PORT_EN];
        end
    end

    // core flags: events set whatever the enables, set wins over a write
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tick_overflow_flag <= 1'b0;
            ext_pin_flag       <= 1'b0;
            port_change_flag   <= 1'b0;
        end
        else
        begin
            if (wr_hit(wr_en, paddr, OFS_CORE_CTRL))
            begin
                tick_overflow_flag <= pwdata[BIT_TICK_FLAG] || tick_rollover;
                ext_pin_flag       <= pwdata[BIT_PIN_FLAG] || pin_event;
                port_change_flag   <= pwdata[BIT_PORT_FLAG] || port_event;
            end
            else
            begin
                tick_overflow_flag <= tick_overflow_flag || tick_rollover;
                ext_pin_flag       <= ext_pin_flag || pin_event;
                port_change_flag   <= port_change_flag || port_event;
            end
        end
    end

    // peripheral request flags, set wins, unused bits of pair two stay zero
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            periph_request_one <= RST_REG;
            periph_request_two <= RST_REG;
        end
        else
        begin
            if (wr_hit(wr_en, paddr, OFS_REQ_ONE))
            begin
                periph_request_one <= pwdata[7:0] | periph_event_one;
            end
            else
            begin
                periph_request_one <= periph_request_one | periph_event_one;
            end
            if (wr_hit(wr_en, paddr, OFS_REQ_TWO))
            begin
                periph_request_two <= (pwdata[7:0] | periph_event_two) & REQ_TWO_MASK;
            end
            else
            begin
                periph_request_two <= (periph_request_two | periph_event_two) & REQ_TWO_MASK;
            end
        end
    end

    // peripheral enables, option and per-pin change enable
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            periph_enable_one     <= RST_REG;
            periph_enable_two     <= RST_REG;
            edge_polarity_select  <= RST_EDGE_POL;
            per_pin_change_enable <= RST_REG;
        end
        else
        begin
            if (wr_hit(wr_en, paddr, OFS_EN_ONE))
            begin
                periph_enable_one <= pwdata[7:0];
            end
            if (wr_hit(wr_en, paddr, OFS_EN_TWO))
            begin
                periph_enable_two <= pwdata[7:0] & REQ_TWO_MASK;
            end
            if (wr_hit(wr_en, paddr, OFS_OPTION))
            begin
                edge_polarity_select <= pwdata[BIT_EDGE_POL];
            end
            if (wr_hit(wr_en, paddr, OFS_PIN_CHANGE))
            begin
                per_pin_change_enable <= pwdata[7:0];
            end
        end
    end

    // sleep state: any enabled flag wakes, gie plays no part
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sleeping <= 1'b0;
            wake_up  <= 1'b0;
        end
        else
        begin
            wake_up <= 1'b0;
            if (sleeping && (core_request || periph_flagged))
            begin
                sleeping <= 1'b0;
                wake_up  <= 1'b1;
            end
            else if (sleep_entry)
            begin
                sleeping <= 1'b1;
            end
        end
    end

    // sequencer: sample at q1, one dummy cycle, jump at the third q1
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            svc_state <= SVC_IDLE;
        end
        else if (q1_en)
        begin
            case (svc_state)
                // sampling starts only once awake, so the instruction after sleep runs
                SVC_IDLE:  svc_state <= (any_request && !sleeping) ? SVC_SYNC
                                                                   : SVC_IDLE;
                // instruction in flight completes, one or two cycle alike
                SVC_SYNC:  svc_state <= any_request ? SVC_DUMMY : SVC_IDLE;
                // jump or give up; an ignored request stays flagged
                SVC_DUMMY: svc_state <= SVC_IDLE;
                default:   svc_state <= SVC_IDLE;
            endcase
        end
    end

    // cpu-facing outputs: jump strobes one clock each at the jump, fixed vector address, pending level
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irq_take    <= 1'b0;
            push_return <= 1'b0;
            vector_load <= 1'b0;
            vector_addr <= VECTOR_ADDR;
            irq_pending <= 1'b0;
        end
        else
        begin
            irq_take    <= take_now;
            push_return <= take_now;
            vector_load <= take_now;
            vector_addr <= VECTOR_ADDR;
            irq_pending <= core_request || periph_flagged;
        end
    end

    // apb slave: zero wait states, error on an unmapped offset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_mapped(paddr);
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    OFS_CORE_CTRL:  prdata <= {24'h000000, core_ctrl_value};
                    OFS_REQ_ONE:    prdata <= {24'h000000, periph_request_one};
                    OFS_REQ_TWO:    prdata <= {24'h000000, periph_request_two};
                    OFS_EN_ONE:     prdata <= {24'h000000, periph_enable_one};
                    OFS_EN_TWO:     prdata <= {24'h000000, periph_enable_two};
                    OFS_OPTION:     prdata <= {31'h00000000, edge_polarity_select};
                    OFS_PIN_CHANGE: prdata <= {24'h000000, per_pin_change_enable};
                    OFS_CPU_STATE:  prdata <= {30'h00000000,
                                               (svc_state != SVC_IDLE), sleeping};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule : mcu_interrupt_aggregator

// file: verif/irq_agg_assertions.sv
// concurrent checks on the aggregator ports
`timescale 1ns/1ps
module irq_agg_assertions (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_entry,
    input wire logic        irq_take,
    input wire logic        push_return,
    input wire logic        vector_load,
    input wire logic [12:0] vector_addr,
    input wire logic        irq_pending,
    input wire logic        wake_up,
    input wire logic        sleeping
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // bus setup cycle and the full vector jump
    sequence s_setup; psel && !penable; endsequence
    sequence s_jump; irq_take && push_return && vector_load; endsequence
    a_apb_answer: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_jump_whole: assert property (irq_take |-> s_jump)
        else $error("jump pulses apart");
    a_vector_fixed: assert property (vector_addr == 13'h0004)
        else $error("vector address wrong");
    a_take_single: assert property (s_jump |=> !irq_take)
        else $error("jump repeated");
    a_take_cause: assert property (irq_take |-> irq_pending)
        else $error("jump without request");
    a_sleep_enter: assert property (sleep_entry && !sleeping |=> sleeping)
        else $error("sleep not entered");
    a_wake_edge: assert property (wake_up |-> !sleeping && $past(sleeping))
        else $error("wake without sleep");
    a_wake_cause: assert property (sleeping && irq_pending |=> wake_up)
        else $error("no wake on request");
    a_no_vector_asleep: assert property (sleeping |-> !irq_take)
        else $error("jump while asleep");
endmodule : irq_agg_assertions
bind mcu_interrupt_aggregator irq_agg_assertions irq_agg_assertions_inst (.ref_clk, .rst_n,
    .psel, .penable, .pready, .pslverr, .sleep_entry, .irq_take, .push_return, .vector_load,
    .vector_addr, .irq_pending, .wake_up, .sleeping);

// file: verif/cpu_core_model.sv
// cpu core stand-in: runs a service routine, then returns
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic irq_take,
    output logic      return_from_irq
);
    logic [5:0] busy_cnt;  // cycles left in the routine
    // count down after a jump, leave with a one-cycle return pulse
    always_ff @(posedge ref_clk)
    begin
        return_from_irq <= 1'b0;
        if (!rst_n)
            busy_cnt <= 6'h00;
        else if (irq_take)
            busy_cnt <= 6'h20;
        else if (busy_cnt != 6'h00)
        begin
            busy_cnt <= busy_cnt - 6'h01;
            return_from_irq <= (busy_cnt == 6'h01);
        end
    end
endmodule : cpu_core_model

// file: verif/mcu_interrupt_aggregator_tb.sv
// register-level bench for the interrupt aggregator
`timescale 1ns/1ps
module mcu_interrupt_aggregator_tb
    import irq_agg_pkg::*;
;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 0, change_port = 0, periph_event_one = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic ext_irq_pin = 0, tick_rollover = 0, sleep_entry = 0, err, return_from_irq;
    logic seg_output_active = 0, port_read = 0, gie_clear_exec = 0;
    logic irq_take, push_return, vector_load, irq_pending, wake_up, sleeping;
    logic [12:0] vector_addr;
    int miscompares = 0, n_tests = 0, takes = 0, lat;
    mcu_interrupt_aggregator mcu_interrupt_aggregator_inst (.ref_clk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin,
        .seg_output_active, .change_port, .port_read, .tick_rollover,
        .periph_event_one, .periph_event_two(8'h00), .sleep_entry, .return_from_irq,
        .gie_clear_exec, .irq_take, .push_return, .vector_load, .vector_addr,
        .irq_pending, .wake_up, .sleeping);
    cpu_core_model cpu_core_model_inst (.ref_clk, .rst_n, .irq_take, .return_from_irq);
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (irq_take === 1'b1) takes++;
    task end_of_test;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one apb transfer, waits for pready under a bound
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
        begin
            miscompares++;
            end_of_test;
        end
    endtask : apb
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("register", rd, exp);
    endtask : rd_chk
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    initial
    begin
        cyc(3);
        rst_n <= 1'b1;
        rd_chk(OFS_CORE_CTRL, 32'h0);
        rd_chk(OFS_OPTION, 32'h1);
        $display("reset done");
        tick_rollover <= 1'b1;
        periph_event_one <= 8'h01;
        cyc(1);
        tick_rollover <= 1'b0;
        periph_event_one <= 8'h00;
        cyc(2);
        rd_chk(OFS_CORE_CTRL, 32'h04);
        rd_chk(OFS_REQ_ONE, 32'h01);
        apb(1'b1, OFS_EN_ONE, 32'h01);
        check("pending", irq_pending, 1'b0);
        apb(1'b1, OFS_CORE_CTRL, 32'h40);
        cyc(2);
        check("pending", irq_pending, 1'b1);
        apb(1'b1, OFS_REQ_ONE, 32'h0);
        apb(1'b1, OFS_REQ_TWO, 32'hff);
        rd_chk(OFS_REQ_TWO, 32'hf5);
        apb(1'b0, 8'h40, 32'h0);
        check("error", err, 1'b1);
        $display("flags done");
        apb(1'b1, OFS_REQ_TWO, 32'h0);
        apb(1'b1, OFS_PIN_CHANGE, 32'h01);
        apb(1'b1, OFS_CORE_CTRL, 32'h08);
        change_port <= 8'h01;
        cyc(6);
        check("pending", irq_pending, 1'b1);
        apb(1'b1, OFS_PIN_CHANGE, 32'h0);
        apb(1'b1, OFS_CORE_CTRL, 32'h90);
        cyc(3);
        check("pending", irq_pending, 1'b0);
        $display("port done");
        ext_irq_pin <= 1'b1;
        for (lat = 0; lat < 40 && irq_take !== 1'b1; lat++) cyc(1);
        check("latency", lat >= 9 && lat <= 18, 1'b1);
        rd_chk(OFS_CORE_CTRL, 32'h12);
        apb(1'b1, OFS_CORE_CTRL, 32'h10);
        cyc(40);
        rd_chk(OFS_CORE_CTRL, 32'h90);
        $display("vector done");
        apb(1'b1, OFS_CORE_CTRL, 32'h10);
        apb(1'b1, OFS_OPTION, 32'h0);
        sleep_entry <= 1'b1;
        cyc(1);
        sleep_entry <= 1'b0;
        cyc(3);
        check("sleeping", sleeping, 1'b1);
        ext_irq_pin <= 1'b0;
        cyc(12);
        check("sleeping", sleeping, 1'b0);
        rd_chk(OFS_CORE_CTRL, 32'h12);
        check("jumps", takes, 1);
        $display("sleep done");
        apb(1'b1, OFS_CORE_CTRL, 32'h10);
        apb(1'b1, OFS_OPTION, 32'h1);
        apb(1'b1, OFS_PIN_CHANGE, 32'h01);
        seg_output_active <= 1'b1;
        ext_irq_pin <= 1'b1;
        port_read <= 1'b1;
        cyc(8);
        port_read <= 1'b0;
        rd_chk(OFS_CORE_CTRL, 32'h10);
        apb(1'b1, OFS_CORE_CTRL, 32'ha0);
        gie_clear_exec <= 1'b1;
        tick_rollover <= 1'b1;
        cyc(1);
        gie_clear_exec <= 1'b0;
        tick_rollover <= 1'b0;
        cyc(16);
        rd_chk(OFS_CORE_CTRL, 32'h24);
        apb(1'b1, OFS_CORE_CTRL, 32'ha4);
        for (lat = 0; lat < 40 && irq_take !== 1'b1; lat++) cyc(1);
        cyc(1);
        check("jumps", takes, 2);
        $display("gating done");
        end_of_test;
    end
endmodule : mcu_interrupt_aggregator_tb
